// ===== rtl/crv_video_path.sv
// Purpose: crt card video path: address selector, latch, text/graphics dots, serialiser,
//          keyboard port with interrupt, card and io select decode
// Assumes: all inputs synchronous to clk_in; display controller supplies refresh address
//          and raster row; dot_tick_in marks one dot time
// Notes:   refresh memory is 4K x 8 inside this module
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - host window 9000-9FFF reaches refresh memory
// - otherwise controller address drives refresh memory
// - video blanked during host refresh access
// - fetched byte captured in refresh latch
// - top bit zero: text via character generator
// - shifter loads pattern, one dot per tick
// - top bit one: graphics pixel conditioning path
// - graphics bit 6 sets brightness
// - six low bits each light one pixel
// - 80x20 format gives 160x60 graphics grid
// - pixel is four dots by four lines
// - strobe polarity from jumper at init
// - strobe latches key data, irq until read
// - card select low when card addressed
// - decode two io select strobes
// - refresh memory up to 4K by 8
module crv_video_path (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] host_addr_in,
    input  wire logic        host_vma_in,
    input  wire logic        host_rw_in,
    input  wire logic [7:0]  host_wdata_in,
    input  wire logic [11:0] crtc_addr_in,
    input  wire logic [3:0]  crtc_row_in,
    input  wire logic        dot_tick_in,
    input  wire logic        kbd_strobe_in,
    input  wire logic [6:0]  kbd_data_in,
    input  wire logic        strobe_jumper_in,
    output logic      [7:0]  host_rdata_out,
    output logic             card_selected_n_out,
    output logic             io1_sel_n_out,
    output logic             io2_sel_n_out,
    output logic             kbd_irq_n_out,
    output logic             video_out,
    output logic             video_bright_out
);
    typedef struct packed {
        logic                       init_done;
        logic                       strobe_pol;
        logic                       strobe_prev;
        logic [6:0]                 kbd_data;
        logic                       kbd_irq_n;
        logic [7:0]                 refresh_latch;
        logic                       host_blank;
        logic [7:0]                 shifter;
        logic [2:0]                 dot_cnt;
        logic                       bright;
        logic [7:0]                 rdata;
        logic                       card_n;
        logic                       io1_n;
        logic                       io2_n;
        crv_pkg::crv_phase_type     phase;
        logic                       video;
        logic                       video_bright;
    } crv_state_type;

    crv_state_type state_reg;
    crv_state_type state_next;

    logic [7:0] refresh_mem [0:(1<<crv_pkg::MEM_AW)-1];
    logic [7:0] mem_q;
    logic [7:0] gen_dots;
    logic [crv_pkg::MEM_AW-1:0] mem_addr;
    logic       host_screen;
    logic       mem_we;

    // address selector
    assign host_screen = host_vma_in && host_addr_in >= crv_pkg::SCREEN_BASE
                         && host_addr_in <= crv_pkg::SCREEN_LAST;
    assign mem_addr = host_screen ? host_addr_in[crv_pkg::MEM_AW-1:0]
                                  : crtc_addr_in;
    assign mem_we = ce_in && host_screen && !host_rw_in;

    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            refresh_mem[mem_addr] <= host_wdata_in;
        end
        if (ce_in) begin
            mem_q <= refresh_mem[mem_addr];
        end
    end

    crv_chargen u_chargen (
        .clk_in   (clk_in),
        .code_in  (state_reg.refresh_latch[6:0]),
        .row_in   (crtc_row_in),
        .dots_out (gen_dots)
    );

    // graphics block: two pixel columns, three pixel rows of four scan lines
    function automatic logic [7:0] gfx_dots(input logic [7:0] b, input logic [3:0] row);
        logic [1:0] prow;
        logic       left;
        logic       right;
        prow  = row[3:2];
        left  = 1'b0;
        right = 1'b0;
        case (prow)
            2'h0: begin left = b[0]; right = b[1]; end
            2'h1: begin left = b[2]; right = b[3]; end
            2'h2: begin left = b[4]; right = b[5]; end
            default: begin left = 1'b0; right = 1'b0; end
        endcase
        // block of 8 dots split as two 4-dot pixels, each a 2-dot group repeated to fill its half
        return {{crv_pkg::GFX_DOT_W{left}}, {crv_pkg::GFX_DOT_W{left}},
                {crv_pkg::GFX_DOT_W{right}}, {crv_pkg::GFX_DOT_W{right}}};
    endfunction

    logic       kbd_edge;
    logic       kbd_read;
    logic       strobe_now;
    logic [15:0] a;

    always_comb begin
        state_next = state_reg;
        a          = host_addr_in;
        strobe_now = kbd_strobe_in ^ ~state_reg.strobe_pol;
        kbd_edge   = state_reg.init_done && strobe_now && !(state_reg.strobe_prev);
        kbd_read   = host_vma_in && host_rw_in && a == crv_pkg::KBD_PORT_ADDR;

        // jumper sampled once after reset release
        if (!state_reg.init_done) begin
            state_next.strobe_pol = strobe_jumper_in;
            state_next.init_done  = 1'b1;
        end
        // before the jumper is known the previous level counts as active, so no false edge follows reset
        state_next.strobe_prev = state_reg.init_done ? strobe_now : 1'b1;

        // set wins over clear by read
        if (kbd_edge) begin
            state_next.kbd_data = kbd_data_in;
            state_next.kbd_irq_n = 1'b0;
        end else if (kbd_read) begin
            state_next.kbd_irq_n = 1'b1;
        end

        state_next.rdata = kbd_read ? {1'b0, state_reg.kbd_data}
                         : (host_screen && host_rw_in) ? mem_q : crv_pkg::DOTS_OFF;
        state_next.card_n = !(host_vma_in && a >= crv_pkg::CARD_BASE
                              && a <= crv_pkg::CARD_LAST);
        state_next.io1_n  = !(host_vma_in && a >= crv_pkg::IO1_BASE && a <= crv_pkg::IO1_LAST);
        state_next.io2_n  = !(host_vma_in && a >= crv_pkg::IO2_BASE && a <= crv_pkg::IO2_LAST);
        state_next.host_blank = host_screen;

        if (dot_tick_in) begin
            case (state_reg.phase)
                crv_pkg::LOAD: begin
                    state_next.refresh_latch = mem_q;
                    state_next.phase = crv_pkg::SHIFT;
                end
                crv_pkg::SHIFT: begin
                    state_next.shifter = {state_reg.shifter[6:0], 1'b0};
                    state_next.dot_cnt = state_reg.dot_cnt + 3'h1;
                    if (state_reg.dot_cnt == crv_pkg::DOT_LAST) begin
                        if (state_reg.refresh_latch[crv_pkg::GFX_FLAG_BIT]) begin
                            state_next.shifter = gfx_dots(state_reg.refresh_latch, crtc_row_in);
                            state_next.bright  = state_reg.refresh_latch[crv_pkg::GFX_BRIGHT_BIT];
                        end else begin
                            state_next.shifter = gen_dots;
                            state_next.bright  = 1'b1;
                        end
                        state_next.phase = crv_pkg::LOAD;
                    end
                end
                default: state_next.phase = crv_pkg::LOAD;
            endcase
            state_next.video        = state_reg.shifter[7] && !host_screen;
            state_next.video_bright = state_reg.bright && state_reg.shifter[7] && !host_screen;
        end
        if (host_screen) begin
            state_next.video        = 1'b0;
            state_next.video_bright = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg        <= '0;
            state_reg.card_n <= 1'b1;
            state_reg.io1_n  <= 1'b1;
            state_reg.io2_n  <= 1'b1;
            state_reg.kbd_irq_n <= 1'b1;
            state_reg.phase  <= crv_pkg::LOAD;
        end else if (ce_in) begin
            state_reg <= state_next;
        end
    end

    assign host_rdata_out      = state_reg.rdata;
    assign card_selected_n_out = state_reg.card_n;
    assign io1_sel_n_out       = state_reg.io1_n;
    assign io2_sel_n_out       = state_reg.io2_n;
    assign kbd_irq_n_out       = state_reg.kbd_irq_n;
    assign video_out           = state_reg.video;
    assign video_bright_out    = state_reg.video_bright;
endmodule
`default_nettype wire

// ===== rtl/crv_pkg.sv
// Purpose: constants shared by the crt refresh video path
// Assumes: 16-bit host address bus, 8-bit data, 125 MHz clock
// Notes:   addresses and field positions are named here only
package crv_pkg;
    localparam logic [15:0] SCREEN_BASE     = 16'h9000;
    localparam logic [15:0] SCREEN_LAST     = 16'h9FFF;
    localparam logic [15:0] IO1_BASE        = 16'h8000;
    localparam logic [15:0] IO1_LAST        = 16'h807F;
    localparam logic [15:0] IO2_BASE        = 16'h8080;
    localparam logic [15:0] IO2_LAST        = 16'h80FF;
    localparam logic [15:0] KBD_PORT_ADDR   = 16'h8008;
    localparam logic [15:0] CARD_BASE       = 16'h8000;
    localparam logic [15:0] CARD_LAST       = 16'h9FFF;
    localparam int          MEM_AW          = 12;
    localparam int          ROW_W           = 4;
    localparam int          DOTS            = 8;
    localparam logic [2:0]  DOT_LAST        = 3'h7;
    localparam int          GFX_FLAG_BIT    = 7;
    localparam int          GFX_BRIGHT_BIT  = 6;
    localparam int          GFX_DOT_W       = 2;
    localparam int          GFX_LINE_H      = 4;
    localparam int          GFX_COLS        = 2;
    localparam logic [7:0]  DOTS_OFF        = 8'h00;
    typedef enum logic [1:0] {
        LOAD,
        SHIFT
    } crv_phase_type;
endpackage

// ===== rtl/crv_chargen.sv
// Purpose: character generator, 4x7 dot rows from code and raster row
// Assumes: no pattern table, dots computed from code and row by logic
// Notes:   row pattern fills bits 6..3 of eight dots, leftmost dot always blank
`timescale 1ns/10ps
`default_nettype none
module crv_chargen (
    input  wire logic                      clk_in,
    input  wire logic [6:0]                code_in,
    input  wire logic [crv_pkg::ROW_W-1:0] row_in,
    output logic      [7:0]                dots_out
);
    // glyphs: simple synthetic pattern, code bits mixed with row, blank rows outside 0..6
    logic [7:0] pat;
    always_comb begin
        pat = crv_pkg::DOTS_OFF;
        if (row_in < 4'h7 && code_in >= 7'h21) begin
            pat = {1'b0, code_in ^ {row_in[2:0], row_in}} & 8'hF8;
        end
    end
    always_ff @(posedge clk_in) begin
        dots_out <= pat;
    end
endmodule
`default_nettype wire

// ===== sim/crv_video_path_sva.sv
// Purpose: port checks for crv_video_path
// Assumes: jumper held constant after reset
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module crv_video_path_sva (
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic        ce_in,
    input wire logic        host_vma_in,
    input wire logic        host_rw_in,
    input wire logic        kbd_strobe_in,
    input wire logic        strobe_jumper_in,
    input wire logic [15:0] host_addr_in,
    input wire logic [7:0]  host_rdata_out,
    input wire logic        card_selected_n_out,
    input wire logic        io1_sel_n_out,
    input wire logic        io2_sel_n_out,
    input wire logic        kbd_irq_n_out,
    input wire logic        video_out,
    input wire logic        video_bright_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic acc, card, scr, io1, io2, kread;
    assign acc   = ce_in && host_vma_in;
    assign card  = acc && host_addr_in >= crv_pkg::CARD_BASE && host_addr_in <= crv_pkg::CARD_LAST;
    assign scr   = acc && host_addr_in >= crv_pkg::SCREEN_BASE && host_addr_in <= crv_pkg::SCREEN_LAST;
    assign io1   = acc && host_addr_in >= crv_pkg::IO1_BASE && host_addr_in <= crv_pkg::IO1_LAST;
    assign io2   = acc && host_addr_in >= crv_pkg::IO2_BASE && host_addr_in <= crv_pkg::IO2_LAST;
    assign kread = acc && host_rw_in && host_addr_in == crv_pkg::KBD_PORT_ADDR;
    sequence s_key_edge; ce_in && strobe_jumper_in && $rose(kbd_strobe_in); endsequence
    sequence s_quiet_read; $stable(kbd_strobe_in) [*4] ##0 kread; endsequence
    sequence s_key_fall; ce_in && !strobe_jumper_in && $fell(kbd_strobe_in); endsequence
    a_key_fall_irq: assert property (s_key_fall |-> ##[1:3] !kbd_irq_n_out)
        else $error("falling key strobe raised no interrupt");
    a_card_sel_low: assert property (card |=> !card_selected_n_out)
        else $error("card select not low");
    a_card_sel_idle: assert property (ce_in && !card |=> card_selected_n_out)
        else $error("card select low when not addressed");
    a_io1_sel_low: assert property (io1 |=> !io1_sel_n_out && io2_sel_n_out)
        else $error("first io select wrong");
    a_io2_sel_low: assert property (io2 |=> !io2_sel_n_out && io1_sel_n_out)
        else $error("second io select wrong");
    a_video_blank: assert property (scr |=> !video_out && !video_bright_out)
        else $error("video not blanked on host access");
    a_key_irq_set: assert property (s_key_edge |-> ##[1:3] !kbd_irq_n_out)
        else $error("key strobe raised no interrupt");
    a_key_irq_hold: assert property (!kbd_irq_n_out && !kread |=> !kbd_irq_n_out)
        else $error("interrupt dropped without read");
    a_key_irq_clear: assert property (s_quiet_read |=> kbd_irq_n_out)
        else $error("interrupt stays after port read");
    a_unmapped_zero: assert property (acc && host_rw_in && host_addr_in >= 16'hA000 |=> host_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_reset_idle: assert property (disable iff (1'b0) srst_in && ce_in |=> card_selected_n_out && io1_sel_n_out
        && io2_sel_n_out && kbd_irq_n_out && !video_out)
        else $error("outputs not idle after reset");
endmodule
bind crv_video_path crv_video_path_sva i_sva (.*);
`default_nettype wire

// ===== sim/crv_crtc_model.sv
// Purpose: display controller stand-in feeding refresh address, row, dot tick
// Assumes: one dot every second clock while running
// Notes:   tick stands still when not running
`timescale 1ns/10ps
`default_nettype none
module crv_crtc_model (
    input  wire logic        clk_in,
    input  wire logic        run_in,
    input  wire logic [11:0] base_in,
    input  wire logic [3:0]  row_in,
    output logic      [11:0] addr_out,
    output logic      [3:0]  row_out,
    output logic             tick_out
);
    initial begin
        tick_out = 1'b0;
        addr_out = 12'h000;
        row_out  = 4'h0;
    end
    always @(posedge clk_in) begin
        tick_out <= run_in && !tick_out;
        addr_out <= base_in;
        row_out  <= row_in;
    end
endmodule
`default_nettype wire

// ===== sim/crv_video_path_tb.sv
// Purpose: self-checking bench for crv_video_path
// Assumes: clock enable high, rising keyboard strobe selected until the falling strobe test
// Notes:   graphics bytes are fully lit or dark
`timescale 1ns/10ps
`default_nettype none
module crv_video_path_tb;
    logic        clk_in = 1'b0, srst_in = 1'b1, vma = 1'b0, rw = 1'b0, stb = 1'b0, run = 1'b0;
    logic        cn, i1, i2, irq_n, vid, bri, tick;
    logic        jmp = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd = 8'h00, rd;
    logic [6:0]  key = 7'h00;
    logic [11:0] caddr;
    logic [3:0]  crow, row = 4'h0;
    int          n_errors = 0, samples_checked = 0;
    always #4 clk_in = ~clk_in;
    crv_video_path i_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .host_addr_in(addr),
        .host_vma_in(vma), .host_rw_in(rw), .host_wdata_in(wd), .crtc_addr_in(caddr), .crtc_row_in(crow),
        .dot_tick_in(tick), .kbd_strobe_in(stb), .kbd_data_in(key), .strobe_jumper_in(jmp),
        .host_rdata_out(rd), .card_selected_n_out(cn), .io1_sel_n_out(i1), .io2_sel_n_out(i2),
        .kbd_irq_n_out(irq_n), .video_out(vid), .video_bright_out(bri));
    crv_crtc_model i_crtc (.clk_in(clk_in), .run_in(run), .base_in(12'h010), .row_in(row),
        .addr_out(caddr), .row_out(crow), .tick_out(tick));
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic [15:0] a, input logic r, input logic [7:0] d, input int n);
        @(posedge clk_in);
        addr <= a;
        rw   <= r;
        wd   <= d;
        vma  <= 1'b1;
        repeat (n) @(posedge clk_in);
        vma <= 1'b0;
        #1;
    endtask
    task automatic t_selects;
        logic [15:0] a [4] = '{16'h8010, 16'h8090, 16'h9005, 16'hA000};
        logic [2:0]  e [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
        for (int i = 0; i < 4; i++) begin
            bus(a[i], 1'b1, 8'h00, 3);
            check("selects", {5'h00, e[i]}, {5'h00, cn, i1, i2});
        end
        check("unmapped read", 8'h00, rd);
    endtask
    task automatic t_memory;
        bus(16'h9005, 1'b0, 8'hA5, 1);
        bus(16'h9FFF, 1'b0, 8'h3C, 1);
        bus(16'h9005, 1'b1, 8'h00, 3);
        check("mem 9005", 8'hA5, rd);
        bus(16'h9FFF, 1'b1, 8'h00, 3);
        check("mem 9FFF", 8'h3C, rd);
    endtask
    task automatic t_key;
        @(posedge clk_in);
        key <= 7'h41;
        stb <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        check("irq set", 8'h00, {7'h00, irq_n});
        bus(crv_pkg::KBD_PORT_ADDR, 1'b1, 8'h00, 1);
        check("key data", 8'h41, rd);
        @(posedge clk_in);
        stb <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check("irq after falling", 8'h01, {7'h00, irq_n});
    endtask
    task automatic t_key_falling;
        @(posedge clk_in);
        srst_in <= 1'b1;
        jmp     <= 1'b0;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        stb <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        check("irq after rising", 8'h01, {7'h00, irq_n});
        @(posedge clk_in);
        key <= 7'h2A;
        stb <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check("irq on falling", 8'h00, {7'h00, irq_n});
        bus(crv_pkg::KBD_PORT_ADDR, 1'b1, 8'h00, 1);
        check("key data falling", 8'h2A, rd);
        check("irq after read", 8'h01, {7'h00, irq_n});
    endtask
    task automatic t_gfx(input logic [7:0] b, input logic [3:0] r, input logic lit, input logic hi, input int thr);
        int nv = 0;
        int nb = 0;
        bus(16'h9010, 1'b0, b, 1);
        @(posedge clk_in);
        row <= r;
        run <= 1'b1;
        repeat (48) @(posedge clk_in);
        repeat (32) begin
            @(posedge clk_in);
            #1;
            nv += int'(vid === 1'b1);
            nb += int'(bri === 1'b1);
        end
        check("lit dots", {7'h00, lit}, {7'h00, nv > thr});
        check("bright dots", {7'h00, hi}, {7'h00, nb > thr});
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        t_selects();
        t_memory();
        t_key();
        t_gfx(8'h80, 4'h0, 1'b0, 1'b0, 16);
        t_gfx(8'hBF, 4'h4, 1'b1, 1'b0, 16);
        t_gfx(8'hFF, 4'h8, 1'b1, 1'b1, 16);
        t_gfx(8'h7F, 4'h0, 1'b1, 1'b1, 0);
        t_gfx(8'h20, 4'h0, 1'b0, 1'b0, 0);
        t_key_falling();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
